// *** logic/core_l2_event_selector.sv ***
// The address map and register access over APB are this design's own decisions.
module core_l2_event_selector #(
    parameter int num_cores = 2
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic simd_forward,
    input wire logic load_forward,
    input wire logic load_penalty_cond,
    input wire logic [num_cores-1:0] addr_bus_busy,
    input wire logic [num_cores-1:0] read_data_busy,
    input wire logic [num_cores-1:0] alloc_valid,
    input wire logic [num_cores-1:0] alloc_prefetch,
    input wire logic [num_cores-1:0] dirty_fill,
    input wire logic [num_cores-1:0] evict_valid,
    input wire logic [num_cores-1:0] evict_prefetch,
    input wire logic [num_cores-1:0] evict_dirty,
    input wire logic [num_cores-1:0] ifetch_req,
    input wire logic [num_cores-1:0] ifetch_uncacheable,
    input wire logic [num_cores-1:0] ifetch_tlb_miss,
    input wire logic [4*num_cores-1:0] ifetch_line_state,
    output logic simd_forward_penalty_event,
    output logic load_stall,
    output logic inc_pulse,
    output logic [$clog2(num_cores+1)-1:0] inc_amount
);
    localparam int cnt_w = $clog2(num_cores + 1);

    // --------------------------------------------------------------
    // Parameter check
    // --------------------------------------------------------------
    if (num_cores < 1 || num_cores > 8) begin : g_bad_cores
        $error("num_cores must be 1 to 8");
    end

    // --------------------------------------------------------------
    // Decoding
    // --------------------------------------------------------------
    function automatic logic [2:0] source_index(input logic [7:0] code);
        case (code)
            l2_event_pkg::code_addr_bus: source_index = 3'h0;
            l2_event_pkg::code_data_bus: source_index = 3'h1;
            l2_event_pkg::code_alloc: source_index = 3'h2;
            l2_event_pkg::code_dirty_fill: source_index = 3'h3;
            l2_event_pkg::code_evict: source_index = 3'h4;
            l2_event_pkg::code_dirty_evict: source_index = 3'h5;
            l2_event_pkg::code_ifetch: source_index = 3'h6;
            default: source_index = l2_event_pkg::src_none;
        endcase
    endfunction

    function automatic logic is_mapped(input logic [7:0] addr);
        is_mapped = addr == l2_event_pkg::ctrl_addr ||
                    addr == l2_event_pkg::count_addr ||
                    addr == l2_event_pkg::status_addr;
    endfunction

    // --------------------------------------------------------------
    // State
    // --------------------------------------------------------------
    logic [31:0] ctrl_r;
    logic [31:0] ctrl_nxt;
    logic [31:0] count_r;
    logic [31:0] count_nxt;
    logic [31:0] prdata_r;
    logic [31:0] prdata_nxt;
    logic pslverr_r;
    logic pslverr_nxt;
    logic inc_pulse_r;
    logic inc_pulse_nxt;
    logic [cnt_w-1:0] inc_r;
    logic [cnt_w-1:0] inc_nxt;

    logic [7:0] code;
    logic [7:0] umask;
    logic enable;
    logic setup;
    logic wr_access;
    logic [2:0] src;
    logic sel_known;
    logic [cnt_w-1:0] src_hits [l2_event_pkg::num_sources];
    logic [num_cores-1:0] src_evt [l2_event_pkg::num_sources];
    logic [num_cores-1:0] src_pf [l2_event_pkg::num_sources];
    logic [num_cores-1:0] fetch_ok;
    logic [cnt_w-1:0] selected;

    assign code = ctrl_r[l2_event_pkg::code_lsb +: 8];
    assign umask = ctrl_r[l2_event_pkg::umask_lsb +: 8];
    assign enable = ctrl_r[l2_event_pkg::enable_bit];
    assign setup = psel && !penable;
    assign wr_access = psel && penable && pwrite && is_mapped(paddr);
    assign src = source_index(code);

    // --------------------------------------------------------------
    // Forwarding penalty stalls
    // --------------------------------------------------------------
    forward_penalty u_forward (
        .pclk(pclk),
        .presetn(presetn),
        .simd_forward(simd_forward),
        .load_forward(load_forward),
        .load_penalty_cond(load_penalty_cond),
        .simd_forward_penalty_event(simd_forward_penalty_event),
        .load_stall(load_stall)
    );

    // --------------------------------------------------------------
    // Cache event sources
    // --------------------------------------------------------------
    assign fetch_ok = ifetch_req & ~ifetch_uncacheable & ~ifetch_tlb_miss;

    always_comb begin
        src_pf[0] = '0;
        src_pf[1] = '0;
        src_pf[2] = alloc_prefetch;
        src_pf[3] = '0;
        src_pf[4] = evict_prefetch;
        src_pf[5] = evict_prefetch;
        src_pf[6] = '0;
        src_evt[0] = addr_bus_busy;
        src_evt[1] = read_data_busy;
        src_evt[2] = alloc_valid;
        src_evt[3] = dirty_fill;
        src_evt[4] = evict_valid;
        src_evt[5] = evict_valid & evict_dirty;
        src_evt[6] = fetch_ok;
    end

    for (genvar s = 0; s < l2_event_pkg::num_sources; s++) begin : g_src
        qual_filter #(
            .num_cores(num_cores),
            .cnt_w(cnt_w)
        ) u_filter (
            .umask(umask),
            .use_pf(s == 2 || s == 4 || s == 5),
            .use_mesi(s == 6),
            .evt(src_evt[s]),
            .pf(src_pf[s]),
            .state(ifetch_line_state),
            .hits(src_hits[s])
        );
    end

    // --------------------------------------------------------------
    // Event selection
    // --------------------------------------------------------------
    always_comb begin
        selected = '0;
        sel_known = 1'b0;
        if (code == l2_event_pkg::code_forward) begin
            if (umask == l2_event_pkg::mask_simd) begin
                selected = cnt_w'(simd_forward_penalty_event);
                sel_known = 1'b1;
            end else if (umask == l2_event_pkg::mask_load) begin
                selected = cnt_w'(load_stall);
                sel_known = 1'b1;
            end
        end else if (src != l2_event_pkg::src_none) begin
            selected = src_hits[src];
            sel_known = 1'b1;
        end
    end

    always_comb begin
        inc_nxt = enable ? selected : '0;
        inc_pulse_nxt = enable && selected != '0;
    end

    // --------------------------------------------------------------
    // Registers over APB
    // --------------------------------------------------------------
    always_comb begin
        ctrl_nxt = ctrl_r;
        count_nxt = count_r + 32'(inc_r);
        if (wr_access && paddr == l2_event_pkg::ctrl_addr) begin
            ctrl_nxt = pwdata;
        end
        if (wr_access && paddr == l2_event_pkg::count_addr) begin
            count_nxt = pwdata + 32'(inc_r);
        end
    end

    always_comb begin
        prdata_nxt = prdata_r;
        pslverr_nxt = pslverr_r;
        if (setup) begin
            pslverr_nxt = !is_mapped(paddr);
            prdata_nxt = '0;
            if (!pwrite) begin
                case (paddr)
                    l2_event_pkg::ctrl_addr: prdata_nxt = ctrl_r;
                    l2_event_pkg::count_addr: prdata_nxt = count_r;
                    l2_event_pkg::status_addr: begin
                        prdata_nxt[l2_event_pkg::stat_valid_bit] = sel_known;
                        prdata_nxt[l2_event_pkg::stat_simd_bit] =
                            simd_forward_penalty_event;
                        prdata_nxt[l2_event_pkg::stat_load_bit] = load_stall;
                    end
                    default: prdata_nxt = '0;
                endcase
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_r <= l2_event_pkg::ctrl_reset;
            count_r <= l2_event_pkg::count_reset;
            prdata_r <= '0;
            pslverr_r <= 1'b0;
            inc_r <= '0;
            inc_pulse_r <= 1'b0;
        end else begin
            ctrl_r <= ctrl_nxt;
            count_r <= count_nxt;
            prdata_r <= prdata_nxt;
            pslverr_r <= pslverr_nxt;
            inc_r <= inc_nxt;
            inc_pulse_r <= inc_pulse_nxt;
        end
    end

    assign prdata = prdata_r;
    assign pready = 1'b1;
    assign pslverr = pslverr_r;
    assign inc_pulse = inc_pulse_r;
    assign inc_amount = inc_r;
endmodule

// *** logic/forward_penalty.sv ***
module forward_penalty (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic simd_forward,
    input wire logic load_forward,
    input wire logic load_penalty_cond,
    output logic simd_forward_penalty_event,
    output logic load_stall
);
    logic simd_stall_r;
    logic simd_stall_nxt;
    logic load_stall_r;
    logic load_stall_nxt;

    // --------------------------------------------------------------
    // One stall cycle after each SIMD forward and after each load forward with load_penalty_cond
    // --------------------------------------------------------------
    always_comb begin
        simd_stall_nxt = simd_forward;
        load_stall_nxt = load_forward && load_penalty_cond;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            simd_stall_r <= 1'b0;
            load_stall_r <= 1'b0;
        end else begin
            simd_stall_r <= simd_stall_nxt;
            load_stall_r <= load_stall_nxt;
        end
    end

    assign simd_forward_penalty_event = simd_stall_r;
    assign load_stall = load_stall_r;
endmodule

// *** logic/qual_filter.sv ***
module qual_filter #(
    parameter int num_cores = 2,
    parameter int cnt_w = 2
) (
    input wire logic [7:0] umask,
    input wire logic use_pf,
    input wire logic use_mesi,
    input wire logic [num_cores-1:0] evt,
    input wire logic [num_cores-1:0] pf,
    input wire logic [4*num_cores-1:0] state,
    output logic [cnt_w-1:0] hits
);
    logic [1:0] core_sel;
    logic [1:0] pf_sel;
    logic [3:0] mesi_sel;
    logic [num_cores-1:0] pass;

    assign core_sel = umask[l2_event_pkg::core_lsb +: 2];
    assign pf_sel = umask[l2_event_pkg::pf_lsb +: 2];
    assign mesi_sel = umask[l2_event_pkg::mesi_lsb +: 4];

    // --------------------------------------------------------------
    // Per-core qualification
    // --------------------------------------------------------------
    for (genvar c = 0; c < num_cores; c++) begin : g_core
        logic core_ok;
        logic pf_ok;
        logic mesi_ok;
        assign core_ok = (core_sel == l2_event_pkg::core_all) ||
                         (core_sel == l2_event_pkg::core_self && c == 0);
        assign pf_ok = !use_pf || pf_sel == l2_event_pkg::pf_both ||
                       (pf_sel == l2_event_pkg::pf_only && pf[c]) ||
                       (pf_sel == l2_event_pkg::pf_demand && !pf[c]);
        assign mesi_ok = !use_mesi || |(state[4*c +: 4] & mesi_sel);
        assign pass[c] = evt[c] && core_ok && pf_ok && mesi_ok;
    end

    always_comb begin
        hits = '0;
        for (int i = 0; i < num_cores; i++) begin
            hits = hits + cnt_w'(pass[i]);
        end
    end
endmodule

// *** pkg/l2_event_pkg.sv ***
package l2_event_pkg;
    // --------------------------------------------------------------
    // Register offsets
    // --------------------------------------------------------------
    localparam logic [7:0] ctrl_addr = 8'h00;
    localparam logic [7:0] count_addr = 8'h04;
    localparam logic [7:0] status_addr = 8'h08;
    localparam logic [31:0] ctrl_reset = 32'h0000_0000;
    localparam logic [31:0] count_reset = 32'h0000_0000;
    // --------------------------------------------------------------
    // Control fields
    // --------------------------------------------------------------
    localparam int code_lsb = 0;
    localparam int umask_lsb = 8;
    localparam int enable_bit = 16;
    // --------------------------------------------------------------
    // Status fields
    // --------------------------------------------------------------
    localparam int stat_valid_bit = 0;
    localparam int stat_simd_bit = 1;
    localparam int stat_load_bit = 2;
    // --------------------------------------------------------------
    // Qualifier fields inside the unit mask
    // --------------------------------------------------------------
    localparam int core_lsb = 6;
    localparam int pf_lsb = 4;
    localparam int mesi_lsb = 0;
    localparam logic [1:0] core_self = 2'h1;
    localparam logic [1:0] core_all = 2'h3;
    localparam logic [1:0] pf_demand = 2'h0;
    localparam logic [1:0] pf_only = 2'h1;
    localparam logic [1:0] pf_both = 2'h3;
    // --------------------------------------------------------------
    // Event codes and masks
    // --------------------------------------------------------------
    localparam logic [7:0] code_forward = 8'h19;
    localparam logic [7:0] mask_simd = 8'h01;
    localparam logic [7:0] mask_load = 8'h02;
    localparam logic [7:0] code_addr_bus = 8'h21;
    localparam logic [7:0] code_data_bus = 8'h23;
    localparam logic [7:0] code_alloc = 8'h24;
    localparam logic [7:0] code_dirty_fill = 8'h25;
    localparam logic [7:0] code_evict = 8'h26;
    localparam logic [7:0] code_dirty_evict = 8'h27;
    localparam logic [7:0] code_ifetch = 8'h28;
    localparam logic [2:0] src_none = 3'h7;
    localparam int num_sources = 7;
    localparam int forward_stall_cycles = 1;
endpackage

// *** test/event_source.sv ***
module event_source (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic fire,
    input wire logic [3:0] sel,
    input wire logic [1:0] bits,
    input wire logic [1:0] aux,
    input wire logic [7:0] st,
    output logic simd_forward,
    output logic load_forward,
    output logic load_penalty_cond,
    output logic [1:0] addr_bus_busy,
    output logic [1:0] read_data_busy,
    output logic [1:0] alloc_valid,
    output logic [1:0] alloc_prefetch,
    output logic [1:0] dirty_fill,
    output logic [1:0] evict_valid,
    output logic [1:0] evict_prefetch,
    output logic [1:0] evict_dirty,
    output logic [1:0] ifetch_req,
    output logic [1:0] ifetch_uncacheable,
    output logic [1:0] ifetch_tlb_miss,
    output logic [7:0] ifetch_line_state
);
    timeunit 1ns;
    timeprecision 1ns;
    // --------------------------------------------------------------
    // One-cycle event burst per request
    // --------------------------------------------------------------
    logic f_r;
    logic [3:0] s_r;
    logic [1:0] b_r;
    logic [1:0] a_r;
    logic [7:0] t_r;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            {f_r, s_r, b_r, a_r, t_r} <= '0;
        end else begin
            {f_r, s_r, b_r, a_r, t_r} <= {fire, sel, bits, aux, st};
        end
    end
    assign simd_forward = f_r && s_r == 4'h0 && b_r[0];
    assign load_forward = f_r && s_r == 4'h1 && b_r[0];
    assign load_penalty_cond = f_r && s_r == 4'h1 && a_r[0];
    assign addr_bus_busy = (f_r && s_r == 4'h2) ? b_r : 2'h0;
    assign read_data_busy = (f_r && s_r == 4'h3) ? b_r : 2'h0;
    assign alloc_valid = (f_r && s_r == 4'h4) ? b_r : 2'h0;
    assign alloc_prefetch = (f_r && s_r == 4'h4) ? a_r : 2'h0;
    assign dirty_fill = (f_r && s_r == 4'h5) ? b_r : 2'h0;
    assign evict_valid = (f_r && s_r inside {6, 7}) ? b_r : 2'h0;
    assign evict_prefetch = (f_r && s_r inside {6, 7}) ? a_r : 2'h0;
    assign evict_dirty = (f_r && s_r == 4'h7) ? b_r : 2'h0;
    assign ifetch_req = (f_r && s_r inside {8, 9}) ? b_r : 2'h0;
    assign ifetch_uncacheable = (f_r && s_r == 4'h8) ? a_r : 2'h0;
    assign ifetch_tlb_miss = (f_r && s_r == 4'h9) ? a_r : 2'h0;
    assign ifetch_line_state = f_r ? t_r : 8'h0;
endmodule

// *** test/l2_event_checker.sv ***
module l2_event_checker #(
    parameter int num_cores = 2
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic simd_forward,
    input wire logic load_forward,
    input wire logic load_penalty_cond,
    input wire logic [num_cores-1:0] addr_bus_busy,
    input wire logic simd_forward_penalty_event,
    input wire logic load_stall,
    input wire logic inc_pulse,
    input wire logic [$clog2(num_cores+1)-1:0] inc_amount
);
    timeunit 1ns;
    timeprecision 1ns;
    // --------------------------------------------------------------
    // Control shadow
    // --------------------------------------------------------------
    logic [31:0] ctrl_r;
    logic [31:0] ctrl_nxt;
    logic unmapped;
    assign unmapped = !(paddr inside {8'h00, 8'h04, 8'h08});
    always_comb begin
        ctrl_nxt = ctrl_r;
        if (psel && penable && pready && pwrite && paddr == 8'h00) begin
            ctrl_nxt = pwdata;
        end
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_r <= 32'h0;
        end else begin
            ctrl_r <= ctrl_nxt;
        end
    end
    // --------------------------------------------------------------
    // Properties
    // --------------------------------------------------------------
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    a_pready_high: assert property (pready)
        else $error("pready low");
    a_slverr_map: assert property (psel && !penable |=>
        pslverr == $past(unmapped)) else $error("pslverr wrong");
    a_simd_stall: assert property (
        simd_forward_penalty_event == $past(simd_forward))
        else $error("simd stall wrong");
    a_load_stall: assert property (
        load_stall == $past(load_forward && load_penalty_cond))
        else $error("load stall wrong");
    a_simd_count: assert property (
        ctrl_r[16:0] == 17'h10119 && simd_forward_penalty_event |=>
        inc_pulse && inc_amount == 1) else $error("simd count");
    a_load_count: assert property (
        ctrl_r[16:0] == 17'h10219 |=> inc_amount == $past(load_stall))
        else $error("load count");
    a_addr_both: assert property (
        ctrl_r[16:0] == 17'h1c021 |=>
        inc_amount == $countones($past(addr_bus_busy)))
        else $error("addr bus count");
    a_amount_max: assert property (inc_amount <= num_cores)
        else $error("amount too big");
    a_pulse_amt: assert property (inc_pulse == (inc_amount != 0))
        else $error("pulse mismatch");
    a_off_quiet: assert property (!ctrl_r[16] |=> !inc_pulse)
        else $error("count while off");
    a_unknown_code: assert property (
        !(ctrl_r[7:0] inside {8'h19, 8'h21, [8'h23:8'h28]}) |=>
        !inc_pulse) else $error("unknown code counted");
    c_simd: cover property (simd_forward_penalty_event ##1 inc_pulse);
    c_both: cover property (inc_amount == 2);
    c_err: cover property (psel && penable && pslverr);
endmodule

// *** test/tb.sv ***
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic pclk = 1'b0;
    logic presetn, psel, penable, pwrite, fire, pready, pslverr, e;
    logic [7:0] paddr, st, ifetch_line_state;
    logic [31:0] pwdata, prdata, q;
    logic [3:0] sel;
    logic [1:0] bits, aux, inc_amount;
    logic simd_forward, load_forward, load_penalty_cond;
    logic [1:0] addr_bus_busy, read_data_busy, alloc_valid, alloc_prefetch;
    logic [1:0] dirty_fill, evict_valid, evict_prefetch, evict_dirty;
    logic [1:0] ifetch_req, ifetch_uncacheable, ifetch_tlb_miss;
    logic simd_forward_penalty_event, load_stall, inc_pulse;
    int n_mismatch = 0;
    int checked = 0;
    always #50 pclk = ~pclk;
    core_l2_event_selector i_dut (.pclk, .presetn, .psel, .penable,
        .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
        .simd_forward, .load_forward, .load_penalty_cond, .addr_bus_busy,
        .read_data_busy, .alloc_valid, .alloc_prefetch, .dirty_fill,
        .evict_valid, .evict_prefetch, .evict_dirty, .ifetch_req,
        .ifetch_uncacheable, .ifetch_tlb_miss, .ifetch_line_state,
        .simd_forward_penalty_event, .load_stall, .inc_pulse, .inc_amount);
    event_source i_src (.pclk, .presetn, .fire, .sel, .bits, .aux, .st,
        .simd_forward, .load_forward, .load_penalty_cond, .addr_bus_busy,
        .read_data_busy, .alloc_valid, .alloc_prefetch, .dirty_fill,
        .evict_valid, .evict_prefetch, .evict_dirty, .ifetch_req,
        .ifetch_uncacheable, .ifetch_tlb_miss, .ifetch_line_state);
    // --------------------------------------------------------------
    // Tasks
    // --------------------------------------------------------------
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        {pwrite, paddr, pwdata} <= {w, a, d};
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        q = prdata;
        e = pslverr;
        {psel, penable} <= 2'b00;
        @(posedge pclk);
    endtask
    task chk(input logic [31:0] g, input logic [31:0] x);
        checked++;
        if (g !== x) begin
            n_mismatch++;
            $display("[FAIL] %0t got %h exp %h", $time, g, x);
        end
    endtask
    task run(input logic [16:0] c, input logic [3:0] s,
        input logic [1:0] b, input logic [1:0] a, input logic [7:0] t,
        input logic [31:0] x);
        apb(1'b1, l2_event_pkg::ctrl_addr, {15'h0, c});
        apb(1'b1, l2_event_pkg::count_addr, 32'h0);
        {fire, sel, bits, aux, st} <= {1'b1, s, b, a, t};
        @(posedge pclk);
        fire <= 1'b0;
        repeat (6) @(posedge pclk);
        apb(1'b0, l2_event_pkg::count_addr, 32'h0);
        chk(q, x);
    endtask
    task stat(input logic [3:0] s, input logic [1:0] a,
        input logic [31:0] x);
        {fire, sel, bits, aux} <= {1'b1, s, 2'h1, a};
        @(posedge pclk);
        fire <= 1'b0;
        @(posedge pclk);
        apb(1'b0, l2_event_pkg::status_addr, 32'h0);
        chk(q, x);
    endtask
    task results;
        $display("mismatches %0d checks %0d", n_mismatch, checked);
        if (n_mismatch == 0 && checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    // --------------------------------------------------------------
    // Sequence
    // --------------------------------------------------------------
    initial begin
        presetn = 1'b0;
        {psel, penable, pwrite, fire, paddr, pwdata} = '0;
        {sel, bits, aux, st} = '0;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(1'b0, l2_event_pkg::ctrl_addr, 32'h0);
        chk(q, l2_event_pkg::ctrl_reset);
        apb(1'b0, l2_event_pkg::count_addr, 32'h0);
        chk(q, l2_event_pkg::count_reset);
        apb(1'b1, l2_event_pkg::count_addr, 32'h0000_a5a5);
        apb(1'b0, l2_event_pkg::count_addr, 32'h0);
        chk(q, 32'h0000_a5a5);
        apb(1'b0, 8'h0c, 32'h0);
        chk({31'h0, e}, 32'h1);
        run(17'h10119, 4'h0, 2'h1, 2'h0, 8'h11, 32'h1);
        stat(4'h0, 2'h0, 32'h3);
        run(17'h10219, 4'h1, 2'h1, 2'h1, 8'h11, 32'h1);
        stat(4'h1, 2'h1, 32'h5);
        run(17'h10219, 4'h1, 2'h1, 2'h0, 8'h11, 32'h0);
        run(17'h1c021, 4'h2, 2'h3, 2'h0, 8'h11, 32'h2);
        run(17'h14021, 4'h2, 2'h3, 2'h0, 8'h11, 32'h1);
        run(17'h1c023, 4'h3, 2'h2, 2'h0, 8'h11, 32'h1);
        run(17'h1f024, 4'h4, 2'h3, 2'h1, 8'h11, 32'h2);
        run(17'h14024, 4'h4, 2'h1, 2'h1, 8'h11, 32'h0);
        run(17'h15024, 4'h4, 2'h3, 2'h3, 8'h11, 32'h1);
        run(17'h1c025, 4'h5, 2'h3, 2'h0, 8'h11, 32'h2);
        run(17'h17026, 4'h6, 2'h3, 2'h2, 8'h11, 32'h1);
        run(17'h1c027, 4'h7, 2'h3, 2'h0, 8'h11, 32'h2);
        run(17'h1c027, 4'h6, 2'h3, 2'h0, 8'h11, 32'h0);
        run(17'h14f28, 4'h8, 2'h1, 2'h0, 8'h11, 32'h1);
        run(17'h14828, 4'h8, 2'h1, 2'h0, 8'h11, 32'h0);
        run(17'h14f28, 4'h8, 2'h1, 2'h1, 8'h11, 32'h0);
        run(17'h14f28, 4'h9, 2'h1, 2'h1, 8'h11, 32'h0);
        run(17'h1c022, 4'h2, 2'h3, 2'h0, 8'h11, 32'h0);
        stat(4'hf, 2'h0, 32'h0);
        run(17'h10319, 4'h0, 2'h1, 2'h0, 8'h11, 32'h0);
        run(17'h0c021, 4'h2, 2'h3, 2'h0, 8'h11, 32'h0);
        run(17'h10021, 4'h2, 2'h3, 2'h0, 8'h11, 32'h0);
        results();
    end
    initial begin
        repeat (5000) @(posedge pclk);
        n_mismatch++;
        results();
    end
endmodule
bind core_l2_event_selector l2_event_checker #(.num_cores(num_cores))
    i_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .pready, .pslverr, .simd_forward, .load_forward, .load_penalty_cond,
    .addr_bus_busy, .simd_forward_penalty_event, .load_stall, .inc_pulse,
    .inc_amount);
